// ==== lmpc_regs.svh ====
// Constants for the LED mode and playback control block.
`ifndef LMPC_REGS_SVH
`define LMPC_REGS_SVH

// ==============================================================
// Operating mode field encodings
`define LMPC_MODE_DIRECT 2'h0
`define LMPC_MODE_AUTO 2'h1
`define LMPC_MODE_AUDIO 2'h2

// ==============================================================
// Reset values
`define LMPC_FRAME_RST 3'h0
`define LMPC_DUTY_RST 8'h00
`define LMPC_MASK8_RST 8'h00

// ==============================================================
// Timing
`define LMPC_CLK_PERIOD_NS 40
`define LMPC_FRAME_BASE_MS 32
`define LMPC_FRAME_BASE_CYC (`LMPC_FRAME_BASE_MS * 1000000 / `LMPC_CLK_PERIOD_NS)
`define LMPC_ADC_BASE_NS 64000
`define LMPC_ADC_BASE_CYC (`LMPC_ADC_BASE_NS / `LMPC_CLK_PERIOD_NS)

// ==============================================================
// Frame store geometry
`define LMPC_CHANNELS 16
`define LMPC_UPPER 8
`define LMPC_MEM_AW 7

`endif

// ==== lmpc_pkg.sv ====
// Types shared by the LED mode and playback control block.
package lmpc_pkg;

    typedef enum logic [1:0] {
        LMPC_PB_DIRECT = 2'b00,
        LMPC_PB_AUTO = 2'b01,
        LMPC_PB_AUDIO = 2'b10
    } lmpc_pb_state_t;

    typedef logic [2:0] lmpc_frame_t;
    typedef logic [7:0] lmpc_duty_t;

endpackage : lmpc_pkg

// ==== lmpc_mem_if.sv ====
// Interface between the playback control and its frame store.
`timescale 1ns/1ps
interface lmpc_mem_if;
    logic wr_en;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : lmpc_mem_if

// ==== lmpc_frame_mem.sv ====
// Eight-frame duty store, sixteen duties per frame, registered read.
`timescale 1ns/1ps
module lmpc_frame_mem (
    input wire logic clk_i,
    lmpc_mem_if.mem bus
);
    logic [7:0] store_r [0:127];
    logic [7:0] rd_data_r;

    always_ff @(posedge clk_i) begin
        if (bus.wr_en) begin
            store_r[bus.wr_addr] <= bus.wr_data;
        end
    end

    always_ff @(posedge clk_i) begin
        rd_data_r <= store_r[bus.rd_addr];
    end

    assign bus.rd_data = rd_data_r;
endmodule : lmpc_frame_mem

// ==== lmpc_top.sv ====
// LED mode and playback control: PWM, frame playback, audio, GPIO, cascade, shutdown.
`include "lmpc_regs.svh"
`timescale 1ns/1ps
module lmpc_top import lmpc_pkg::*; #(
    parameter int FRAME_BASE_CYCLES = `LMPC_FRAME_BASE_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [1:0] mode_i,
    input wire logic soft_powerdown_n_i,
    input wire logic hard_powerdown_pin_n_i,
    input wire logic audio_modulation_enable_i,
    input wire logic [2:0] audio_gain_i,
    input wire logic [2:0] frame_interval_code_i,
    input wire logic [2:0] first_frame_code_i,
    input wire logic [7:0] sample_rate_i,
    input wire logic [7:0] adc_sample_i,
    input wire logic [127:0] pwm_direct_i,
    input wire logic frame_wr_i,
    input wire logic [6:0] frame_wr_addr_i,
    input wire logic [7:0] frame_wr_data_i,
    input wire logic [7:0] channel_function_bit_i,
    input wire logic [7:0] gpio_is_input_i,
    input wire logic [7:0] gpio_out_level_i,
    input wire logic [7:0] gpio_irq_enable_i,
    input wire logic state_read_i,
    input wire logic [7:0] upper_channel_pins_i,
    input wire logic cascade_role_select_i,
    input wire logic cascade_clk_in_i,
    output logic [15:0] led_drive_o,
    output logic [7:0] upper_channel_pins_o,
    output logic [7:0] upper_channel_pins_oe_o,
    output logic [7:0] state_value_o,
    output logic interrupt_out_n_o,
    output logic cascade_clk_out_o,
    output logic cascade_clk_oe_o,
    output logic [2:0] frame_o
);

    // ==============================================================
    // Helpers

    // Gain steps of about 3 dB as multipliers in eighths.
    function automatic logic [6:0] lmpc_gain_mult(input logic [2:0] code);
        case (code)
            3'h0: lmpc_gain_mult = 7'h08;
            3'h1: lmpc_gain_mult = 7'h0B;
            3'h2: lmpc_gain_mult = 7'h10;
            3'h3: lmpc_gain_mult = 7'h17;
            3'h4: lmpc_gain_mult = 7'h20;
            3'h5: lmpc_gain_mult = 7'h2D;
            3'h6: lmpc_gain_mult = 7'h40;
            default: lmpc_gain_mult = 7'h5B;
        endcase
    endfunction : lmpc_gain_mult

    // Eight equal bands of the sample range; band 0 shows frame 0.
    function automatic lmpc_frame_t lmpc_band(input logic [7:0] sample);
        lmpc_band = sample[7:5];
    endfunction : lmpc_band

    // ==============================================================
    // Playback state

    lmpc_pb_state_t pb_r;
    lmpc_pb_state_t pb_nxt;
    lmpc_frame_t frame_r;
    logic [31:0] frame_timer_r;
    logic [31:0] frame_limit;
    logic [10:0] adc_base_r;
    logic [7:0] adc_div_r;
    logic adc_take;
    logic [7:0] audio_level_r;
    logic [14:0] gained;

    assign frame_limit = 32'(FRAME_BASE_CYCLES) << frame_interval_code_i;

    always_comb begin
        case (mode_i)
            `LMPC_MODE_AUTO: pb_nxt = LMPC_PB_AUTO;
            `LMPC_MODE_AUDIO: pb_nxt = LMPC_PB_AUDIO;
            default: pb_nxt = LMPC_PB_DIRECT;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pb_r <= LMPC_PB_DIRECT;
        end else begin
            pb_r <= pb_nxt;
        end
    end

    // The sample clock keeps running in every mode; a rate of zero never samples.
    assign adc_take = (adc_base_r == 11'(`LMPC_ADC_BASE_CYC - 1)) && (sample_rate_i != 8'h00)
        && (adc_div_r >= sample_rate_i - 8'h01);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            adc_base_r <= 11'h000;
            adc_div_r <= 8'h00;
        end else if (adc_base_r == 11'(`LMPC_ADC_BASE_CYC - 1)) begin
            adc_base_r <= 11'h000;
            adc_div_r <= adc_take ? 8'h00 : adc_div_r + 8'h01;
        end else begin
            adc_base_r <= adc_base_r + 11'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            frame_r <= `LMPC_FRAME_RST;
            frame_timer_r <= 32'h0000_0000;
        end else begin
            case (pb_r)
                LMPC_PB_AUTO: begin
                    if (pb_nxt != LMPC_PB_AUTO) begin
                        frame_timer_r <= 32'h0000_0000;
                    end else if (frame_timer_r >= frame_limit - 32'h1) begin
                        frame_timer_r <= 32'h0000_0000;
                        frame_r <= frame_r + 3'h1;
                    end else begin
                        frame_timer_r <= frame_timer_r + 32'h1;
                    end
                end
                LMPC_PB_AUDIO: begin
                    frame_timer_r <= 32'h0000_0000;
                    if (adc_take) begin
                        frame_r <= lmpc_band(adc_sample_i);
                    end
                end
                LMPC_PB_DIRECT: begin
                    frame_timer_r <= 32'h0000_0000;
                    frame_r <= first_frame_code_i;
                end
                default: begin
                    frame_timer_r <= 32'h0000_0000;
                end
            endcase
            // Entering auto play always starts from the chosen first frame.
            if (pb_nxt == LMPC_PB_AUTO && pb_r != LMPC_PB_AUTO) begin
                frame_r <= first_frame_code_i;
            end
        end
    end

    assign frame_o = frame_r;

    // Audio level with gain, saturated at full scale.
    assign gained = adc_sample_i * lmpc_gain_mult(audio_gain_i);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            audio_level_r <= 8'h00;
        end else begin
            audio_level_r <= (gained[14:11] != 4'h0) ? 8'hFF : gained[10:3];
        end
    end

    // ==============================================================
    // Frame store scan

    lmpc_mem_if mem_bus ();
    logic [3:0] scan_r;
    logic [3:0] scan_d_r;
    lmpc_duty_t shadow_r [0:15];

    lmpc_frame_mem u_mem (
        .clk_i(clk_i),
        .bus(mem_bus.mem)
    );

    assign mem_bus.wr_en = frame_wr_i;
    assign mem_bus.wr_addr = frame_wr_addr_i;
    assign mem_bus.wr_data = frame_wr_data_i;
    assign mem_bus.rd_addr = {frame_r, scan_r};

    // One duty per cycle is refreshed, so a frame change settles in 17 cycles.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            scan_r <= 4'h0;
            scan_d_r <= 4'h0;
        end else begin
            scan_r <= scan_r + 4'h1;
            scan_d_r <= scan_r;
        end
    end

    always_ff @(posedge clk_i) begin
        shadow_r[scan_d_r] <= mem_bus.rd_data;
    end

    // ==============================================================
    // Cascade time base

    logic casc_div_r;
    logic casc_in_prev_r;
    logic pwm_tick;
    logic [7:0] pwm_cnt_r;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            casc_div_r <= 1'b0;
            casc_in_prev_r <= 1'b0;
        end else begin
            casc_div_r <= ~casc_div_r;
            casc_in_prev_r <= cascade_clk_in_i;
        end
    end

    assign pwm_tick = cascade_role_select_i ? (cascade_clk_in_i & ~casc_in_prev_r)
                                            : ~casc_div_r;
    assign cascade_clk_out_o = casc_div_r & ~cascade_role_select_i;
    assign cascade_clk_oe_o = ~cascade_role_select_i;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pwm_cnt_r <= 8'h00;
        end else if (pwm_tick) begin
            pwm_cnt_r <= pwm_cnt_r + 8'h01;
        end
    end

    // ==============================================================
    // Channel outputs

    logic powered;
    logic [15:0] led_drive_r;

    assign powered = soft_powerdown_n_i & hard_powerdown_pin_n_i;

    genvar ch;
    generate
        for (ch = 0; ch < `LMPC_CHANNELS; ch++) begin : g_ch
            lmpc_duty_t duty_src;
            logic [15:0] scaled;
            lmpc_duty_t duty_eff;
            logic is_gpio;

            assign duty_src = (pb_r == LMPC_PB_DIRECT) ? pwm_direct_i[ch*8 +: 8]
                                                       : shadow_r[ch];
            assign scaled = duty_src * audio_level_r;
            assign duty_eff = audio_modulation_enable_i ? scaled[15:8] : duty_src;
            if (ch >= `LMPC_UPPER) begin : g_up
                assign is_gpio = channel_function_bit_i[ch - `LMPC_UPPER];
            end else begin : g_low
                assign is_gpio = 1'b0;
            end

            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    led_drive_r[ch] <= 1'b0;
                end else begin
                    led_drive_r[ch] <= powered && !is_gpio && (pwm_cnt_r < duty_eff);
                end
            end
        end
    endgenerate

    assign led_drive_o = led_drive_r;

    // ==============================================================
    // Upper channel GPIO and input-change interrupt

    logic [7:0] pin_out_r;
    logic [7:0] pin_oe_r;
    logic [7:0] pin_prev_r;
    logic [7:0] state_r;
    logic [7:0] watch;
    logic pending_r;
    logic change;

    // GPIO ignores shutdown so the pins stay usable while the LEDs are dark.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_out_r <= `LMPC_MASK8_RST;
            pin_oe_r <= `LMPC_MASK8_RST;
        end else begin
            pin_out_r <= gpio_out_level_i & channel_function_bit_i;
            pin_oe_r <= channel_function_bit_i & ~gpio_is_input_i;
        end
    end

    assign upper_channel_pins_o = pin_out_r;
    assign upper_channel_pins_oe_o = pin_oe_r;

    assign watch = channel_function_bit_i & gpio_is_input_i & gpio_irq_enable_i;
    assign change = |((upper_channel_pins_i ^ pin_prev_r) & watch);

    // Tracked through reset too, so a pin resting high is no false change after it.
    always_ff @(posedge clk_i) begin
        pin_prev_r <= upper_channel_pins_i;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= `LMPC_MASK8_RST;
        end else begin
            state_r <= upper_channel_pins_i;
        end
    end

    // A change in the read cycle wins, so no event is lost.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pending_r <= 1'b0;
        end else if (change) begin
            pending_r <= 1'b1;
        end else if (state_read_i) begin
            pending_r <= 1'b0;
        end
    end

    assign state_value_o = state_r;
    assign interrupt_out_n_o = ~pending_r;

endmodule : lmpc_top

// ==== lmpc_pin_model.sv ====
// Board model around the upper channel pins: outside drivers and a pull-up.
`timescale 1ns/1ps
module lmpc_pin_model (
    input wire logic [7:0] dut_level_i,
    input wire logic [7:0] dut_oe_i,
    input wire logic [7:0] ext_level_i,
    input wire logic [7:0] ext_oe_i,
    output logic [7:0] pin_o
);
    // An undriven pin rests high through the pull-up, never at its last driven level.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_o[i] = dut_oe_i[i] ? dut_level_i[i] : (ext_oe_i[i] ? ext_level_i[i] : 1'b1);
        end
    end
endmodule : lmpc_pin_model

// ==== lmpc_top_assertions.sv ====
// Concurrent checks on the ports of the LED mode and playback control block.
`timescale 1ns/1ps
module lmpc_top_assertions (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic soft_powerdown_n_i,
    input wire logic hard_powerdown_pin_n_i,
    input wire logic [7:0] channel_function_bit_i,
    input wire logic [7:0] gpio_is_input_i,
    input wire logic [7:0] gpio_irq_enable_i,
    input wire logic state_read_i,
    input wire logic [7:0] upper_channel_pins_i,
    input wire logic cascade_role_select_i,
    input wire logic [15:0] led_drive_o,
    input wire logic [7:0] upper_channel_pins_oe_o,
    input wire logic interrupt_out_n_o,
    input wire logic cascade_clk_out_o,
    input wire logic cascade_clk_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    chk_soft_off_dark: assert property (!soft_powerdown_n_i [*2] |-> led_drive_o == 16'h0000)
        else $error("soft shutdown left a channel on");
    chk_hard_off_dark: assert property (!hard_powerdown_pin_n_i [*2] |-> led_drive_o == 16'h0000)
        else $error("hard shutdown left a channel on");
    chk_irq_on_change: assert property (|((upper_channel_pins_i ^ $past(upper_channel_pins_i))
        & channel_function_bit_i & gpio_is_input_i & gpio_irq_enable_i) |=> !interrupt_out_n_o)
        else $error("input change did not raise interrupt");
    chk_irq_hold_low: assert property (!interrupt_out_n_o && !state_read_i |=> !interrupt_out_n_o)
        else $error("interrupt released without a read");
    chk_irq_read_clear: assert property (!interrupt_out_n_o && state_read_i
        && !(|((upper_channel_pins_i ^ $past(upper_channel_pins_i)) & channel_function_bit_i
        & gpio_is_input_i & gpio_irq_enable_i)) |=> interrupt_out_n_o)
        else $error("interrupt not released after read");
    chk_gpio_out_en: assert property (1'b1 |=>
        upper_channel_pins_oe_o == $past(channel_function_bit_i & ~gpio_is_input_i))
        else $error("pin enable does not follow GPIO output setting");
    chk_master_clk_en: assert property (cascade_clk_oe_o == !cascade_role_select_i)
        else $error("cascade pin direction wrong");
    chk_slave_clk_quiet: assert property (cascade_role_select_i |-> !cascade_clk_out_o)
        else $error("slave drives cascade clock");
endmodule : lmpc_top_assertions

bind lmpc_top lmpc_top_assertions chk_u (
    .clk_i(clk_i), .reset_i(reset_i), .soft_powerdown_n_i(soft_powerdown_n_i),
    .hard_powerdown_pin_n_i(hard_powerdown_pin_n_i),
    .channel_function_bit_i(channel_function_bit_i), .gpio_is_input_i(gpio_is_input_i),
    .gpio_irq_enable_i(gpio_irq_enable_i), .state_read_i(state_read_i),
    .upper_channel_pins_i(upper_channel_pins_i), .cascade_role_select_i(cascade_role_select_i),
    .led_drive_o(led_drive_o), .upper_channel_pins_oe_o(upper_channel_pins_oe_o),
    .interrupt_out_n_o(interrupt_out_n_o), .cascade_clk_out_o(cascade_clk_out_o),
    .cascade_clk_oe_o(cascade_clk_oe_o));

// ==== lmpc_top_tb.sv ====
// Self-checking testbench for the LED mode and playback control block.
`timescale 1ns/1ps
module lmpc_top_tb;
    import lmpc_pkg::*;
    logic clk_i = 1'b0, reset_i = 1'b1, soft_n = 1'b1, hard_n = 1'b1, role = 1'b0, amod = 1'b0;
    logic cas_in = 1'b0, wr = 1'b0, rd = 1'b0, irq_n, cas_o, cas_oe;
    logic [1:0] mode = 2'h0;
    logic [2:0] ivl = 3'h0, first = 3'h0, gain = 3'h0;
    logic [6:0] wa = 7'h00;
    logic [7:0] rate = 8'h00, adc = 8'h00, func = 8'h00, is_in = 8'h00, lvl = 8'h00;
    logic [7:0] ien = 8'h00, ext = 8'h00, wd = 8'h00, pins, pins_o, pins_oe, state;
    logic [15:0] led;
    logic [127:0] pwm = 128'h0;
    lmpc_frame_t frame;
    int n_errors = 0;
    int num_checks = 0;
    int duty [4] = '{0, 1, 73, 152};

    initial forever #20 clk_i = ~clk_i;
    // The slave PWM counter steps on each rising cascade edge: one every two cycles.
    always @(posedge clk_i) cas_in <= role ? ~cas_in : 1'b0;

    lmpc_top #(.FRAME_BASE_CYCLES(20)) dut_u (
        .clk_i(clk_i), .reset_i(reset_i), .mode_i(mode), .soft_powerdown_n_i(soft_n),
        .hard_powerdown_pin_n_i(hard_n), .audio_modulation_enable_i(amod),
        .audio_gain_i(gain), .frame_interval_code_i(ivl), .first_frame_code_i(first),
        .sample_rate_i(rate), .adc_sample_i(adc), .pwm_direct_i(pwm), .frame_wr_i(wr),
        .frame_wr_addr_i(wa), .frame_wr_data_i(wd), .channel_function_bit_i(func),
        .gpio_is_input_i(is_in), .gpio_out_level_i(lvl), .gpio_irq_enable_i(ien),
        .state_read_i(rd), .upper_channel_pins_i(pins), .cascade_role_select_i(role),
        .cascade_clk_in_i(cas_in), .led_drive_o(led), .upper_channel_pins_o(pins_o),
        .upper_channel_pins_oe_o(pins_oe), .state_value_o(state), .interrupt_out_n_o(irq_n),
        .cascade_clk_out_o(cas_o), .cascade_clk_oe_o(cas_oe), .frame_o(frame));

    lmpc_pin_model pin_u (.dut_level_i(pins_o), .dut_oe_i(pins_oe), .ext_level_i(ext),
        .ext_oe_i(8'h03), .pin_o(pins));

    task automatic end_sim();
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wait_cyc

    // Counts cycles until the shown frame moves on, giving up after 200.
    task automatic wait_step(output int n);
        lmpc_frame_t f;
        f = frame;
        n = 0;
        do begin
            wait_cyc(1);
            n++;
        end while (frame === f && n < 200);
    endtask : wait_step

    // Counts lit cycles of channel c over one full 512-cycle PWM period.
    task automatic count_on(input int c, output int n);
        n = 0;
        for (int i = 0; i < 512; i++) begin
            wait_cyc(1);
            n += (led[c] === 1'b1);
        end
    endtask : count_on

    // ==========================================================
    // Scenarios
    task automatic pwm_case(input logic slave, input logic on);
        int n;
        logic c0;
        @(posedge clk_i);
        role <= slave;
        soft_n <= on;
        mode <= 2'h0;
        pwm <= {96'h0, 8'h98, 8'h49, 8'h01, 8'h00};
        wait_cyc(600);
        c0 = cas_o;
        wait_cyc(1);
        chk(16'(cas_oe), 16'(!slave));
        chk(16'(cas_o), slave ? 16'h0000 : 16'(!c0));
        for (int c = 0; c < 4; c++) begin
            count_on(c, n);
            chk(16'(n), on ? 16'(2 * duty[c]) : 16'h0000);
        end
    endtask : pwm_case

    task automatic gpio_case();
        @(posedge clk_i);
        hard_n <= 1'b0;
        func <= 8'h83;
        is_in <= 8'h03;
        ien <= 8'h01;
        lvl <= 8'hFF;
        wait_cyc(3);
        chk(pins_oe, 8'h80);
        chk(pins_o & pins_oe, 8'h80);
        chk(led, 16'h0000);
        @(posedge clk_i);
        ext <= 8'h02;
        wait_cyc(3);
        chk(irq_n, 1'b1);
        @(posedge clk_i);
        ext <= 8'h03;
        wait_cyc(4);
        chk(irq_n, 1'b0);
        @(posedge clk_i);
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        wait_cyc(2);
        chk(irq_n, 1'b1);
        chk(state, 8'hFF);
        @(posedge clk_i);
        hard_n <= 1'b1;
    endtask : gpio_case

    task automatic auto_case();
        int gap;
        @(posedge clk_i);
        first <= 3'h6;
        ivl <= 3'h1;
        mode <= 2'h1;
        wait_cyc(4);
        chk(frame, 3'h6);
        wait_step(gap);
        chk(frame, 3'h7);
        wait_step(gap);
        chk(frame, 3'h0);
        chk(16'(gap), 16'(20 << 1));
    endtask : auto_case

    task automatic audio_case();
        int n;
        @(posedge clk_i);
        soft_n <= 1'b1;
        wr <= 1'b1;
        wa <= 7'h70;
        wd <= 8'hFF;
        @(posedge clk_i);
        wr <= 1'b0;
        mode <= 2'h2;
        rate <= 8'h01;
        adc <= 8'h00;
        wait_cyc(1700);
        chk(frame, 3'h0);
        @(posedge clk_i);
        adc <= 8'hFF;
        wait_cyc(1700);
        chk(frame, 3'h7);
        count_on(0, n);
        chk(16'(n), 16'(2 * 255));
        // Level 224 at unity gain scales duty 255 to 223; the next gain step clips the level at 255, giving duty 254.
        @(posedge clk_i);
        adc <= 8'hE0;
        amod <= 1'b1;
        wait_cyc(4);
        count_on(0, n);
        chk(16'(n), 16'(2 * 223));
        @(posedge clk_i);
        gain <= 3'h1;
        wait_cyc(4);
        count_on(0, n);
        chk(16'(n), 16'(2 * 254));
        @(posedge clk_i);
        adc <= 8'h9F;
        wait_cyc(1700);
        chk(frame, 3'h4);
    endtask : audio_case

    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        pwm_case(1'b0, 1'b1);
        pwm_case(1'b1, 1'b1);
        pwm_case(1'b0, 1'b0);
        gpio_case();
        auto_case();
        audio_case();
        end_sim();
    end
endmodule : lmpc_top_tb
